//--- logic/p2m_defs.svh
// Constants for the upper port-2 pin multiplexer: bit positions, codes and reset values.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef P2M_DEFS_SVH
`define P2M_DEFS_SVH

`define P2M_BIT_STE 2
`define P2M_BIT_SVS 3
`define P2M_BIT_TXD 4
`define P2M_BIT_RXD 5
`define P2M_BIT_SW6 6
`define P2M_BIT_SW7 7
`define P2M_PAD_LO 2
`define P2M_PAD_HI 5
`define P2M_SVS_ALL_ONES 4'hF
`define P2M_RST_BITS 6'h00
`define P2M_RST_PADS 4'h0
`define P2M_RST_OE_N 4'hF
`define P2M_SYNC_STAGES 2

`endif

//--- logic/p2m_pkg.sv
// Types shared by the upper port-2 pin multiplexer files.
// Assumes p2m_defs.svh is reachable on the include path.
`include "p2m_defs.svh"

package p2m_pkg;
   typedef logic [7:2] p2m_bits_t;
   typedef logic [5:2] p2m_pads_t;
   typedef logic [3:0] p2m_level_t;
endpackage : p2m_pkg

//--- logic/p2m_sync.sv
// Two-flop level synchroniser for the bonded pad inputs.
// Assumes pads are asynchronous to core_clk; output is the second stage only.
`timescale 1ns/100ps
`include "p2m_defs.svh"

module p2m_sync
   import p2m_pkg::*;
(
   input wire logic core_clk, // System clock
   input wire logic nrst, // Asynchronous reset, active low
   input wire logic ce, // Clock enable, freezes state when low
   input wire p2m_pads_t din, // Raw pad levels
   output p2m_pads_t dout // Synchronised pad levels
);

   p2m_pads_t stage1;

   // First stage feeds only the second stage to keep metastability contained
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         stage1 <= `P2M_RST_PADS;
         dout <= `P2M_RST_PADS;
      end else if (ce) begin
         stage1 <= din;
         dout <= stage1;
      end
   end

endmodule : p2m_sync

//--- logic/p2m_port.sv
// Pin multiplexer and general-purpose logic for port-2 bits 2 to 7.
// Assumes the port control bits are held by software-facing registers outside and arrive as
// plain levels; the flag write strobe is a single-cycle pulse synchronous to core_clk.
`timescale 1ns/100ps
`include "p2m_defs.svh"

////////////////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - Digital path of pins 2-5 works only while its analog-disable gate is low.
// - Bit 2 forced input in module mode; module output low; pad feeds slave tx-enable.
// - Bit 3 direction from its own direction bit; module output constant low.
// - Bit 3 analog-disable gate asserts only when supply-monitor level is all ones.
// - Bit 4 forced output in module mode, driving serial transmit data to the pad.
// - Bit 5 forced input in module mode, module output low, pad feeds serial receive.
// - Bits 6 and 7 keep all registers, no pads, module output low, own direction.
// - Flags of bits 6 and 7 change only through software writes.
// - Interrupt request raised when any set flag has its enable bit set.
module p2m_port
   import p2m_pkg::*;
(
   input wire logic core_clk, // System clock, 25 MHz
   input wire logic nrst, // Asynchronous reset, active low
   input wire logic ce, // Clock enable, freezes all state when low
   input wire p2m_bits_t pin_function_select, // 1 selects the module function
   input wire p2m_bits_t pin_direction_bit, // 1 selects output in port mode
   input wire p2m_bits_t pin_output_value, // Port-mode output levels
   input wire p2m_bits_t pin_irq_enable, // Per-bit interrupt enable
   input wire p2m_bits_t pin_irq_edge_select, // 0 rising, 1 falling
   input wire logic pin_irq_flag_wr, // One-cycle software write strobe for the flags
   input wire p2m_bits_t pin_irq_flag_wdata, // Flag values written by software
   input wire p2m_level_t supply_monitor_level, // Supply-monitor level field
   input wire logic serial_tx_out, // Transmit data from the serial unit
   input wire p2m_pads_t pad_in, // Pad input levels
   output p2m_pads_t pad_out, // Pad output levels
   output p2m_pads_t pad_oe_n, // Pad output enable, low while driving
   output p2m_bits_t pin_input_value, // Readback of synchronised pad levels
   output p2m_bits_t pin_irq_flag, // Interrupt flags
   output p2m_bits_t pin_dir_effective, // Direction actually applied, 1 output
   output p2m_pads_t analog_input_disable_gate, // Gates that block the digital path
   output logic serial_slave_tx_enable, // Pad level to serial slave tx-enable
   output logic serial_rx_in, // Pad level to serial receive
   output logic port_irq // Port interrupt request
);

   p2m_pads_t pad_sync;
   p2m_pads_t pad_prev;
   p2m_pads_t gate;
   p2m_pads_t hw_set;
   p2m_bits_t mod_dir;
   p2m_bits_t mod_out;
   p2m_bits_t next_dir;
   p2m_bits_t next_val;
   p2m_bits_t next_flag;

   // Edge match for one pin: rising when select is 0, falling when 1
   function automatic logic edge_hit(input logic prev, input logic cur, input logic fall);
      edge_hit = fall ? (prev & ~cur) : (~prev & cur);
   endfunction : edge_hit

   ////////////////////////////////////////////////////////////////////////////////////////
   // Pad input path

   p2m_sync u_sync (
      .core_clk(core_clk),
      .nrst(nrst),
      .ce(ce),
      .din(pad_in),
      .dout(pad_sync)
   );

   always_comb begin
      gate = `P2M_RST_PADS;
      gate[`P2M_BIT_SVS] = (supply_monitor_level == `P2M_SVS_ALL_ONES);
   end

   // Previous sample of the gated level for edge detection
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         pad_prev <= `P2M_RST_PADS;
      end else if (ce) begin
         pad_prev <= pad_sync & ~gate;
      end
   end

   always_comb begin
      hw_set = `P2M_RST_PADS;
      for (int i = `P2M_PAD_LO; i <= `P2M_PAD_HI; i++) begin
         hw_set[i] = edge_hit(pad_prev[i], pad_sync[i] & ~gate[i], pin_irq_edge_select[i]);
      end
   end

   // Gated input readback; padless bits read zero
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         pin_input_value <= `P2M_RST_BITS;
         serial_slave_tx_enable <= 1'b0;
         serial_rx_in <= 1'b0;
         analog_input_disable_gate <= `P2M_RST_PADS;
      end else if (ce) begin
         pin_input_value <= {2'h0, pad_sync & ~gate};
         serial_slave_tx_enable <= pad_sync[`P2M_BIT_STE];
         serial_rx_in <= pad_sync[`P2M_BIT_RXD];
         analog_input_disable_gate <= gate;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // Direction and output multiplexing

   always_comb begin
      mod_dir = pin_direction_bit;
      mod_dir[`P2M_BIT_STE] = 1'b0;
      mod_dir[`P2M_BIT_TXD] = 1'b1;
      mod_dir[`P2M_BIT_RXD] = 1'b0;
      mod_out = `P2M_RST_BITS;
      mod_out[`P2M_BIT_TXD] = serial_tx_out;
      for (int i = 2; i <= 7; i++) begin
         next_dir[i] = pin_function_select[i] ? mod_dir[i] : pin_direction_bit[i];
         next_val[i] = pin_function_select[i] ? mod_out[i] : pin_output_value[i];
      end
   end

   // A disabled digital path leaves the pad undriven; driven level is registered
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         pad_out <= `P2M_RST_PADS;
         pad_oe_n <= `P2M_RST_OE_N;
         pin_dir_effective <= `P2M_RST_BITS;
      end else if (ce) begin
         pad_out <= next_val[5:2];
         pad_oe_n <= ~(next_dir[5:2] & ~gate);
         pin_dir_effective <= next_dir;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // Interrupt flags

   // Hardware set wins over a software write in the same cycle
   always_comb begin
      next_flag = pin_irq_flag_wr ? pin_irq_flag_wdata : pin_irq_flag;
      next_flag[5:2] = next_flag[5:2] | hw_set;
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         pin_irq_flag <= `P2M_RST_BITS;
      end else if (ce) begin
         pin_irq_flag <= next_flag;
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         port_irq <= 1'b0;
      end else if (ce) begin
         port_irq <= |(pin_irq_flag & pin_irq_enable);
      end
   end

endmodule : p2m_port

//--- sim/p2m_port_assertions.sv
// Checker for the upper port-2 pin multiplexer.
// Assumes outputs register one edge after the controls, three after the pads.
`timescale 1ns/100ps
module p2m_port_chk
   import p2m_pkg::*;
(
   input wire logic core_clk, nrst, ce, pin_irq_flag_wr, serial_tx_out,
   input wire logic serial_slave_tx_enable, serial_rx_in, port_irq,
   input wire p2m_bits_t pin_function_select, pin_direction_bit, pin_output_value, pin_irq_enable,
   input wire p2m_bits_t pin_irq_flag_wdata, pin_input_value, pin_irq_flag, pin_dir_effective,
   input wire p2m_level_t supply_monitor_level,
   input wire p2m_pads_t pad_in, pad_out, pad_oe_n, analog_input_disable_gate
);
   logic [2:0] hist;
   // Live edges only, so $past never looks into reset
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) hist <= 3'h0;
      else hist <= {hist[1:0], ce};
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (!nrst);
   property p_gate; hist[0] |-> analog_input_disable_gate == {2'h0, $past(supply_monitor_level) == 4'hF, 1'h0}; endproperty
   a_gate: assert property (p_gate) else $error("gate");
   property p_shut; analog_input_disable_gate[3] |-> pad_oe_n[3] && !pin_input_value[3]; endproperty
   a_shut: assert property (p_shut) else $error("shut");
   property p_in2; hist[0] && $past(pin_function_select[2]) |-> pad_oe_n[2] && !pin_dir_effective[2]; endproperty
   a_in2: assert property (p_in2) else $error("in2");
   property p_ser; &hist |-> {serial_rx_in, serial_slave_tx_enable} == {$past(pad_in[5], 3), $past(pad_in[2], 3)}; endproperty
   a_ser: assert property (p_ser) else $error("ser");
   property p_tx; hist[0] && $past(pin_function_select[4]) |-> !pad_oe_n[4] && pad_out[4] == $past(serial_tx_out); endproperty
   a_tx: assert property (p_tx) else $error("tx");
   property p_gpo; hist[0] && $past(pin_direction_bit[2]) && !$past(pin_function_select[2])
      |-> !pad_oe_n[2] && pad_out[2] == $past(pin_output_value[2]); endproperty
   a_gpo: assert property (p_gpo) else $error("gpo");
   property p_own; hist[0] |-> {pin_dir_effective[7:6], pin_dir_effective[3]} == {$past(pin_direction_bit[7:6]),
      $past(pin_direction_bit[3])}; endproperty
   a_own: assert property (p_own) else $error("own");
   property p_sw; hist[0] && !$past(pin_irq_flag_wr) |-> $stable(pin_irq_flag[7:6]); endproperty
   a_sw: assert property (p_sw) else $error("sw");
   property p_irq; hist[0] |-> port_irq == |($past(pin_irq_flag) & $past(pin_irq_enable)); endproperty
   a_irq: assert property (p_irq) else $error("irq");
endmodule : p2m_port_chk

bind p2m_port p2m_port_chk p2m_port_chk_i (.*);

//--- sim/p2m_far_model.sv
// Pads with board drive, and the serial unit's transmit source.
// Assumes a driven pad reads back its own drive.
`timescale 1ns/100ps
module p2m_far_model
   import p2m_pkg::*;
(
   input wire p2m_pads_t ext_drive, // Board level on released pads
   input wire p2m_pads_t pad_out, // Port drive
   input wire p2m_pads_t pad_oe_n, // Low while driving
   input wire logic tx_bit, // Serial transmit bit
   output p2m_pads_t pad_in, // Resolved pads
   output logic serial_tx_out // To the port
);
   assign pad_in = (pad_out & ~pad_oe_n) | (ext_drive & pad_oe_n);
   assign serial_tx_out = tx_bit;
endmodule : p2m_far_model

//--- sim/test_p2m_port.sv
// Self-checking bench for p2m_port; inputs change at the falling edge.
`timescale 1ns/100ps
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin n_fail++; $display("ERROR %s exp %h got %h", n, e, a); end end
module test_p2m_port
   import p2m_pkg::*;
;
   logic core_clk = 0, nrst = 0, ce = 1, pin_irq_flag_wr = 0, tx_bit = 0;
   logic serial_tx_out, serial_slave_tx_enable, serial_rx_in, port_irq;
   p2m_bits_t pin_function_select = 0, pin_direction_bit = 0, pin_output_value = 0, pin_irq_enable = 0;
   p2m_bits_t pin_irq_edge_select = 0, pin_irq_flag_wdata = 0, pin_input_value, pin_irq_flag, pin_dir_effective;
   p2m_level_t supply_monitor_level = 0;
   p2m_pads_t ext_drive = 0, pad_in, pad_out, pad_oe_n, analog_input_disable_gate;
   int n_fail = 0, num_checks = 0;
   always #20 core_clk = ~core_clk;
   p2m_port p2m_port_i (.*);
   p2m_far_model p2m_far_model_i (.*);
   task step(input int n); repeat (n) @(negedge core_clk); endtask : step
   task wr_flag(input p2m_bits_t v);
      pin_irq_flag_wdata = v;
      pin_irq_flag_wr = 1;
      step(1);
      pin_irq_flag_wr = 0;
      step(2);
   endtask : wr_flag
   task complete_run;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : complete_run
   initial begin
      step(10);
      `CHK("rst oe_n", 4'hF, pad_oe_n)
      step(10);
      nrst = 1;
      pin_direction_bit = 6'h3F; pin_output_value = 6'h2A; step(6);
      `CHK("pad_out", 4'hA, pad_out)
      `CHK("readback", 6'h0A, pin_input_value)
      $display("test port done");
      pin_function_select = 6'h3F; pin_direction_bit = 0; ext_drive = 4'hB; tx_bit = 1; step(6);
      `CHK("mod oe_n", 4'hB, pad_oe_n)
      `CHK("mod out", 4'h4, pad_out)
      `CHK("ste rx", 2'h3, {serial_slave_tx_enable, serial_rx_in})
      pin_direction_bit = 6'h3F; tx_bit = 0; step(2);
      `CHK("mod dir", 6'h36, pin_dir_effective)
      `CHK("mod low", 4'h0, pad_out)
      $display("test module done");
      pin_function_select = 0;
      for (int i = 0; i < 16; i++) begin
         supply_monitor_level = 4'(i); step(5);
         `CHK("gate", {2'h0, i == 15, 1'h0}, analog_input_disable_gate)
      end
      `CHK("gated", 2'h2, {pad_oe_n[3], pin_input_value[3]})
      supply_monitor_level = 0; pin_direction_bit = 0; ext_drive = 0; step(6); wr_flag(0);
      ext_drive = 4'hF; step(5);
      `CHK("rise", 4'hF, pin_irq_flag[5:2])
      wr_flag(0); pin_irq_edge_select = 6'h3F; ext_drive = 0; step(5);
      `CHK("fall", 4'hF, pin_irq_flag[5:2])
      wr_flag(0); ext_drive = 4'hF; step(5);
      `CHK("no rise", 6'h00, pin_irq_flag)
      $display("test edges done");
      pin_irq_enable = 6'h20; wr_flag(6'h10);
      `CHK("sw flag", 6'h10, pin_irq_flag)
      `CHK("masked", 1'h0, port_irq)
      wr_flag(6'h20);
      `CHK("irq", 1'h1, port_irq)
      $display("test flags done");
      ce = 0; pin_direction_bit = 6'h3F; step(3);
      `CHK("frozen oe_n", 4'hF, pad_oe_n)
      `CHK("frozen flag", 6'h20, pin_irq_flag)
      ce = 1; step(2);
      `CHK("thawed oe_n", 4'h0, pad_oe_n)
      $display("test enable done");
      complete_run();
   end
endmodule : test_p2m_port
